// *** adc_config_register_map.sv ***
// Upper control register bank of a dual-channel converter with channel routing.
// Assumes a serial port front end delivering one-cycle byte writes and level reads.
// How it works
// RQ1: Lane field bits 6:4 decode into five serialization modes.
// RQ2: Serial output control resets to 0x32, double-rate two-lane bytewise.
// RQ3: Channel index bits 1:0 pick data channels taking per-channel writes.
// RQ4: Channel index also selects clock output channels for per-channel settings.
// RQ5: Global registers reach all channels; only local ones follow the index.
// RQ6: Clock output channels accept only a reduced subset of per-channel settings.
// RQ7: Host sets one-lane wordwise and low-encode mode below 20 MSPS.
// RQ8: Writes act at once, except override, applied by transfer bit zero.
// RQ9: Override rate code limits maximum rate capability, not conversion rate.
// RQ10: I/O control two bit zero disables the data pin pull-down.
// RQ11: I/O control three bit three powers down the common-mode generator.
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_map #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  // Register port
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  input  wire logic [9:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  output logic                     reg_hit,
  // Global settings
  output logic [15:0]              test_pattern_one,
  output logic [15:0]              test_pattern_two,
  output var adc_regmap_pkg::lane_mode_type lane_mode,
  output logic                     double_rate,
  output logic                     one_lane,
  output logic                     lsb_first,
  output logic                     low_encode_mode,
  output logic                     two_frame,
  output logic [1:0]               output_bits,
  // Per-channel settings
  output logic [CHANNELS-1:0]      channel_power_down,
  output logic [CHANNELS-1:0]      channel_output_reset,
  output logic                     clock_output_reset,
  // Applied override
  output logic                     override_enable,
  output logic [1:0]               override_resolution,
  output logic [2:0]               max_rate_limit,
  // Pad and analog controls
  output logic                     sdio_pull_down_off,
  output logic                     common_mode_generator_down
);
  logic [7:0] index_q, index_d;
  logic [7:0] p1l_q, p1l_d, p1h_q, p1h_d, p2l_q, p2l_d, p2h_q, p2h_d;
  logic [7:0] soc_q, soc_d;
  logic [CHANNELS-1:0] pd_q, pd_d, rst_q, rst_d;
  logic       clk_rst_q, clk_rst_d;
  logic [7:0] shadow_q, shadow_d, active_q, active_d;
  logic [7:0] io2_q, io2_d, io3_q, io3_d;
  logic [7:0] rdata_d;
  logic [7:0] cpr_view;
  logic       wr_cpr;
  logic       clock_sel;

  assign wr_cpr    = reg_write && (reg_addr == adc_regmap_pkg::ADDR_CHANNEL_POWER);
  // RQ4: clock output selection
  assign clock_sel = index_q[adc_regmap_pkg::IDX_CLOCK_FCO] || index_q[adc_regmap_pkg::IDX_CLOCK_DCO];

  always_comb begin
    index_d   = index_q;
    p1l_d     = p1l_q;
    p1h_d     = p1h_q;
    p2l_d     = p2l_q;
    p2h_d     = p2h_q;
    soc_d     = soc_q;
    shadow_d  = shadow_q;
    active_d  = active_q;
    io2_d     = io2_q;
    io3_d     = io3_q;
    clk_rst_d = clk_rst_q;
    // RQ5: global registers ignore index
    if (reg_write) begin
      case (reg_addr)
        adc_regmap_pkg::ADDR_CHANNEL_INDEX:    index_d = reg_wdata;
        adc_regmap_pkg::ADDR_PATTERN_ONE_LOW:  p1l_d = reg_wdata;
        adc_regmap_pkg::ADDR_PATTERN_ONE_HIGH: p1h_d = reg_wdata;
        adc_regmap_pkg::ADDR_PATTERN_TWO_LOW:  p2l_d = reg_wdata;
        adc_regmap_pkg::ADDR_PATTERN_TWO_HIGH: p2h_d = reg_wdata;
        adc_regmap_pkg::ADDR_SERIAL_OUTPUT:    soc_d = reg_wdata;
        // RQ8: override held in shadow
        adc_regmap_pkg::ADDR_RATE_OVERRIDE:    shadow_d = reg_wdata & 8'h77;
        adc_regmap_pkg::ADDR_IO_CONTROL_TWO:   io2_d = reg_wdata & 8'h01;
        adc_regmap_pkg::ADDR_IO_CONTROL_THREE: io3_d = reg_wdata & 8'h08;
        default: ;
      endcase
    end
    // RQ8: transfer applies shadow
    if (reg_write && (reg_addr == adc_regmap_pkg::ADDR_TRANSFER) && reg_wdata[adc_regmap_pkg::XFER_BIT]) begin
      active_d = shadow_q;
    end
    // RQ6: clock outputs take reset only
    if (wr_cpr && clock_sel) begin
      clk_rst_d = reg_wdata[adc_regmap_pkg::CPR_OUT_RESET];
    end
  end

  // RQ3: index gates per-channel writes
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      always_comb begin
        pd_d[g]  = pd_q[g];
        rst_d[g] = rst_q[g];
        if (wr_cpr && index_q[adc_regmap_pkg::IDX_DATA_LSB + g]) begin
          pd_d[g]  = reg_wdata[adc_regmap_pkg::CPR_POWER_DOWN];
          rst_d[g] = reg_wdata[adc_regmap_pkg::CPR_OUT_RESET];
        end
      end
    end
  endgenerate

  // Read back shows the first selected data channel, as a multi-select has no single value.
  always_comb begin
    cpr_view = adc_regmap_pkg::RESET_ZERO;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (index_q[adc_regmap_pkg::IDX_DATA_LSB + i]) begin
        cpr_view = {6'h00, rst_q[i], pd_q[i]};
      end
    end
    rdata_d = adc_regmap_pkg::RESET_ZERO;
    reg_hit = 1'b1;
    case (reg_addr)
      adc_regmap_pkg::ADDR_CHANNEL_INDEX:    rdata_d = index_q;
      adc_regmap_pkg::ADDR_PATTERN_ONE_LOW:  rdata_d = p1l_q;
      adc_regmap_pkg::ADDR_PATTERN_ONE_HIGH: rdata_d = p1h_q;
      adc_regmap_pkg::ADDR_PATTERN_TWO_LOW:  rdata_d = p2l_q;
      adc_regmap_pkg::ADDR_PATTERN_TWO_HIGH: rdata_d = p2h_q;
      adc_regmap_pkg::ADDR_SERIAL_OUTPUT:    rdata_d = soc_q;
      adc_regmap_pkg::ADDR_CHANNEL_POWER:    rdata_d = cpr_view;
      adc_regmap_pkg::ADDR_TRANSFER:         rdata_d = adc_regmap_pkg::RESET_ZERO;
      adc_regmap_pkg::ADDR_RATE_OVERRIDE:    rdata_d = shadow_q;
      adc_regmap_pkg::ADDR_IO_CONTROL_TWO:   rdata_d = io2_q;
      adc_regmap_pkg::ADDR_IO_CONTROL_THREE: rdata_d = io3_q;
      default:                               reg_hit = 1'b0;
    endcase
    if (!reg_read) begin
      rdata_d = reg_rdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      index_q   <= adc_regmap_pkg::RESET_CHANNEL_INDEX;
      p1l_q     <= adc_regmap_pkg::RESET_ZERO;
      p1h_q     <= adc_regmap_pkg::RESET_ZERO;
      p2l_q     <= adc_regmap_pkg::RESET_ZERO;
      p2h_q     <= adc_regmap_pkg::RESET_ZERO;
      // RQ2: serial control default
      soc_q     <= adc_regmap_pkg::RESET_SERIAL_OUTPUT;
      pd_q      <= '0;
      rst_q     <= '0;
      clk_rst_q <= 1'b0;
      shadow_q  <= adc_regmap_pkg::RESET_ZERO;
      active_q  <= adc_regmap_pkg::RESET_ZERO;
      io2_q     <= adc_regmap_pkg::RESET_ZERO;
      io3_q     <= adc_regmap_pkg::RESET_ZERO;
      reg_rdata <= adc_regmap_pkg::RESET_ZERO;
    end else begin
      index_q   <= index_d;
      p1l_q     <= p1l_d;
      p1h_q     <= p1h_d;
      p2l_q     <= p2l_d;
      p2h_q     <= p2h_d;
      soc_q     <= soc_d;
      pd_q      <= pd_d;
      rst_q     <= rst_d;
      clk_rst_q <= clk_rst_d;
      shadow_q  <= shadow_d;
      active_q  <= active_d;
      io2_q     <= io2_d;
      io3_q     <= io3_d;
      reg_rdata <= rdata_d;
    end
  end

  lane_decoder u_lane (
    .lane_field  (soc_q[adc_regmap_pkg::SOC_LANE_LSB +: 3]),
    .lane_mode   (lane_mode),
    .double_rate (double_rate),
    .one_lane    (one_lane)
  );

  assign test_pattern_one     = {p1h_q, p1l_q};
  assign test_pattern_two     = {p2h_q, p2l_q};
  assign lsb_first            = soc_q[adc_regmap_pkg::SOC_MSB_FIRST];
  // RQ7: low encode flag for host
  assign low_encode_mode      = soc_q[adc_regmap_pkg::SOC_LOW_ENCODE];
  assign two_frame            = soc_q[adc_regmap_pkg::SOC_TWO_FRAME];
  assign output_bits          = soc_q[1:0];
  assign channel_power_down   = pd_q;
  assign channel_output_reset = rst_q;
  assign clock_output_reset   = clk_rst_q;
  assign override_enable      = active_q[adc_regmap_pkg::ROV_ENABLE];
  assign override_resolution  = active_q[adc_regmap_pkg::ROV_RES_LSB +: 2];
  // RQ9: capability limit only
  assign max_rate_limit       = active_q[2:0];
  // RQ10: pull-down disable
  assign sdio_pull_down_off   = io2_q[adc_regmap_pkg::IO2_PULL_OFF];
  // RQ11: common-mode power-down
  assign common_mode_generator_down = io3_q[adc_regmap_pkg::IO3_COMMON_MODE_DOWN];

  // RQ8: override waits for transfer
  AST_OVERRIDE_HELD: assert property ( // RQ8
    @(posedge core_clk) disable iff (!reset_n)
    !(reg_write && reg_addr == adc_regmap_pkg::ADDR_TRANSFER && reg_wdata[0])
    |=> $stable(max_rate_limit))
    else $error("override changed without transfer");
  AST_TRANSFER_APPLIES: assert property ( // RQ8
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && reg_addr == adc_regmap_pkg::ADDR_TRANSFER && reg_wdata[0])
    |=> (max_rate_limit == $past(shadow_q[2:0])))
    else $error("transfer did not apply rate code");
  AST_SERIAL_DEFAULT: assert property ( // RQ2
    @(posedge core_clk)
    $rose(reset_n) |-> (lane_mode == adc_regmap_pkg::LANE_DOUBLE_TWO_BYTE))
    else $error("serial control default wrong");
  AST_ONE_LANE: assert property ( // RQ1
    @(posedge core_clk) disable iff (!reset_n)
    one_lane |-> (soc_q[6:4] == 3'b100) && double_rate)
    else $error("one lane decode wrong");
  AST_UNSELECTED_KEEPS: assert property ( // RQ3
    @(posedge core_clk) disable iff (!reset_n)
    (wr_cpr && !index_q[0]) |=> (pd_q[0] == $past(pd_q[0])))
    else $error("unselected channel changed");
  AST_SELECTED_TAKES: assert property ( // RQ3
    @(posedge core_clk) disable iff (!reset_n)
    (wr_cpr && index_q[1]) |=> (pd_q[1] == $past(reg_wdata[0])))
    else $error("selected channel missed write");
  AST_GLOBAL_PATTERN: assert property ( // RQ5
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && reg_addr == adc_regmap_pkg::ADDR_PATTERN_ONE_LOW)
    |=> (test_pattern_one[7:0] == $past(reg_wdata)))
    else $error("global pattern write lost");
  AST_CLOCK_SUBSET: assert property ( // RQ6
    @(posedge core_clk) disable iff (!reset_n)
    (wr_cpr && clock_sel) |=> (clock_output_reset == $past(reg_wdata[1])))
    else $error("clock output reset not applied");
  AST_COMMON_MODE_DOWN: assert property ( // RQ11
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && reg_addr == adc_regmap_pkg::ADDR_IO_CONTROL_THREE)
    |=> (common_mode_generator_down == $past(reg_wdata[3])))
    else $error("common-mode control wrong");
  AST_PULL_OFF: assert property ( // RQ10
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && reg_addr == adc_regmap_pkg::ADDR_IO_CONTROL_TWO)
    |=> (sdio_pull_down_off == $past(reg_wdata[0])))
    else $error("pull-down control wrong");
endmodule // adc_config_register_map
`default_nettype wire

// *** adc_regmap_pkg.sv ***
// Register map constants for the converter's upper control registers.
// Assumes a serial control port front end that presents byte-wide register accesses.
package adc_regmap_pkg;
  localparam logic [9:0] ADDR_CHANNEL_INDEX    = 10'h005;
  localparam logic [9:0] ADDR_PATTERN_ONE_LOW  = 10'h019;
  localparam logic [9:0] ADDR_PATTERN_ONE_HIGH = 10'h01A;
  localparam logic [9:0] ADDR_PATTERN_TWO_LOW  = 10'h01B;
  localparam logic [9:0] ADDR_PATTERN_TWO_HIGH = 10'h01C;
  localparam logic [9:0] ADDR_SERIAL_OUTPUT    = 10'h021;
  localparam logic [9:0] ADDR_CHANNEL_POWER    = 10'h022;
  localparam logic [9:0] ADDR_TRANSFER         = 10'h0FF;
  localparam logic [9:0] ADDR_RATE_OVERRIDE    = 10'h100;
  localparam logic [9:0] ADDR_IO_CONTROL_TWO   = 10'h101;
  localparam logic [9:0] ADDR_IO_CONTROL_THREE = 10'h102;

  localparam logic [7:0] RESET_CHANNEL_INDEX = 8'h0F;
  localparam logic [7:0] RESET_SERIAL_OUTPUT = 8'h32;
  localparam logic [7:0] RESET_ZERO          = 8'h00;

  // Channel index bit positions: two data channels, two clock outputs.
  localparam int IDX_DATA_LSB  = 0;
  localparam int IDX_CLOCK_FCO = 4;
  localparam int IDX_CLOCK_DCO = 5;

  localparam int SOC_LANE_LSB   = 4;
  localparam int SOC_MSB_FIRST  = 7;
  localparam int SOC_LOW_ENCODE = 3;
  localparam int SOC_TWO_FRAME  = 2;
  localparam int CPR_POWER_DOWN = 0;
  localparam int CPR_OUT_RESET  = 1;
  localparam int ROV_ENABLE     = 6;
  localparam int ROV_RES_LSB    = 4;
  localparam int IO2_PULL_OFF   = 0;
  localparam int IO3_COMMON_MODE_DOWN = 3;
  localparam int XFER_BIT       = 0;

  typedef enum logic [2:0] {
    LANE_SINGLE_TWO_BIT  = 3'b000,
    LANE_SINGLE_TWO_BYTE = 3'b001,
    LANE_DOUBLE_TWO_BIT  = 3'b010,
    LANE_DOUBLE_TWO_BYTE = 3'b011,
    LANE_DOUBLE_ONE_WORD = 3'b100,
    LANE_INVALID         = 3'b111
  } lane_mode_type;
endpackage

// *** lane_decoder.sv ***
// Decoder for the serial output lane field.
// Assumes the field comes straight from the control register.
`timescale 1ns/1ps
`default_nettype none
module lane_decoder (
  // Field in
  input  wire logic [2:0]                   lane_field,
  // Decoded mode
  output var  adc_regmap_pkg::lane_mode_type lane_mode,
  output logic                              double_rate,
  output logic                              one_lane
);
  always_comb begin
    // RQ1: lane code decode
    case (lane_field)
      3'b000:  lane_mode = adc_regmap_pkg::LANE_SINGLE_TWO_BIT;
      3'b001:  lane_mode = adc_regmap_pkg::LANE_SINGLE_TWO_BYTE;
      3'b010:  lane_mode = adc_regmap_pkg::LANE_DOUBLE_TWO_BIT;
      3'b011:  lane_mode = adc_regmap_pkg::LANE_DOUBLE_TWO_BYTE;
      3'b100:  lane_mode = adc_regmap_pkg::LANE_DOUBLE_ONE_WORD;
      default: lane_mode = adc_regmap_pkg::LANE_INVALID;
    endcase
    double_rate = (lane_mode == adc_regmap_pkg::LANE_DOUBLE_TWO_BIT) ||
                  (lane_mode == adc_regmap_pkg::LANE_DOUBLE_TWO_BYTE) ||
                  (lane_mode == adc_regmap_pkg::LANE_DOUBLE_ONE_WORD);
    one_lane    = (lane_mode == adc_regmap_pkg::LANE_DOUBLE_ONE_WORD);
  end
endmodule // lane_decoder
`default_nettype wire

// *** reg_host_model.sv ***
// Host side of the byte register port: issues one write or read per call.
// Assumes the block takes a strobe at the rising edge after it is driven.
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output var  logic       reg_write,
  output var  logic       reg_read,
  output var  logic [9:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit
);
  initial begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 10'h000;
    reg_wdata = 8'h00;
  end

  // Idle address and data are inverted so that a stale value is never taken for a live one.
  task automatic access(input logic wr, input logic [9:0] addr, input logic [7:0] data,
                        output logic [7:0] rdata, output logic hit);
    @(posedge core_clk);
    reg_write <= wr;
    reg_read  <= ~wr;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge core_clk);
    hit = reg_hit;
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    reg_addr  <= ~addr;
    reg_wdata <= ~data;
    #1;
    rdata = reg_rdata;
  endtask
endmodule // reg_host_model
`default_nettype wire

// *** adc_config_register_map_bench.sv ***
// Self-checking bench for the upper register bank, compared with a model after every access.
// Assumes the package, the design files and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_map_bench;
  logic core_clk, reset_n, reg_write, reg_read, reg_hit, double_rate, one_lane, lsb_first;
  logic low_encode_mode, two_frame, clock_output_reset, override_enable;
  logic sdio_pull_down_off, common_mode_generator_down;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] test_pattern_one, test_pattern_two;
  logic [1:0] output_bits, channel_power_down, channel_output_reset, override_resolution;
  logic [2:0] max_rate_limit;
  adc_regmap_pkg::lane_mode_type lane_mode;
  logic [7:0] idx, soc, shd, app, io2, io3;
  logic [7:0] p [4];
  logic [1:0] pd, rs;
  logic crs;
  int fails = 0;
  int n_tests = 0;
  int seed = 32'hc4469a46;
  logic [9:0] addrs [13] = '{10'h000, 10'h005, 10'h019, 10'h01A, 10'h01B, 10'h01C, 10'h021,
                             10'h022, 10'h0FF, 10'h100, 10'h101, 10'h102, 10'h3FF};
  logic [7:0] idxs [7] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h20, 8'h00, 8'h33};

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  reg_host_model u_host (.core_clk(core_clk), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

  adc_config_register_map #(.CHANNELS(2)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .test_pattern_one(test_pattern_one),
    .test_pattern_two(test_pattern_two), .lane_mode(lane_mode), .double_rate(double_rate),
    .one_lane(one_lane), .lsb_first(lsb_first), .low_encode_mode(low_encode_mode),
    .two_frame(two_frame), .output_bits(output_bits), .channel_power_down(channel_power_down),
    .channel_output_reset(channel_output_reset), .clock_output_reset(clock_output_reset),
    .override_enable(override_enable), .override_resolution(override_resolution),
    .max_rate_limit(max_rate_limit), .sdio_pull_down_off(sdio_pull_down_off),
    .common_mode_generator_down(common_mode_generator_down));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic model_reset();
    idx = 8'h0F;
    soc = 8'h32;
    {shd, app, io2, io3, pd, rs, crs} = '0;
    p = '{8'h00, 8'h00, 8'h00, 8'h00};
  endtask

  task automatic chk_outs();
    check({p[1], p[0]}, test_pattern_one);
    check({p[3], p[2]}, test_pattern_two);
    check(16'(lane_mode), 16'((soc[6:4] > 3'h4) ? 3'h7 : soc[6:4]));
    if (soc[6:4] <= 3'h4) check(16'({double_rate, one_lane}), 16'({soc[6:4] > 3'h1, soc[6:4] == 3'h4}));
    check(16'({lsb_first, low_encode_mode, two_frame, output_bits}), 16'({soc[7], soc[3:0]}));
    check(16'({channel_power_down, channel_output_reset, clock_output_reset}), 16'({pd, rs, crs}));
    check(16'({override_enable, override_resolution, max_rate_limit}), 16'({app[6:4], app[2:0]}));
    check(16'({sdio_pull_down_off, common_mode_generator_down}), 16'({io2[0], io3[3]}));
  endtask

  task automatic mwr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] rd;
    logic h;
    u_host.access(1'b1, a, d, rd, h);
    case (a)
      10'h005: idx = d;
      10'h019, 10'h01A, 10'h01B, 10'h01C: p[a - 10'h019] = d;
      10'h021: soc = d;
      10'h022: begin
        for (int c = 0; c < 2; c++) if (idx[c]) {rs[c], pd[c]} = d[1:0];
        // Clock outputs only take the output reset bit.
        if (idx[5:4] != 2'b00) crs = d[1];
      end
      10'h0FF: if (d[0]) app = shd;
      10'h100: shd = d;
      10'h101: io2 = d;
      10'h102: io3 = d;
      default: ;
    endcase
    chk_outs();
  endtask

  task automatic mrd(input logic [9:0] a);
    logic [7:0] rd, w;
    logic h;
    u_host.access(1'b0, a, 8'h00, rd, h);
    case (a)
      10'h005: w = idx;
      10'h019, 10'h01A, 10'h01B, 10'h01C: w = p[a - 10'h019];
      10'h021: w = soc;
      10'h022: w = idx[0] ? {6'h00, rs[0], pd[0]} : (idx[1] ? {6'h00, rs[1], pd[1]} : 8'h00);
      10'h100: w = shd & 8'h77;
      10'h101: w = io2 & 8'h01;
      10'h102: w = io3 & 8'h08;
      default: w = 8'h00;
    endcase
    check(16'(rd), 16'(w));
    check(16'(h), 16'(a inside {10'h005, 10'h019, 10'h01A, 10'h01B, 10'h01C, 10'h021, 10'h022,
                                10'h0FF, 10'h100, 10'h101, 10'h102}));
  endtask

  task automatic read_all();
    foreach (addrs[i]) mrd(addrs[i]);
  endtask

  initial begin
    #2500000;
    fails++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    model_reset();
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk_outs();
    read_all();
    // Every lane code, with code 4 paired with low encode mode as a slow-rate host does.
    for (int c = 0; c < 8; c++) begin
      mwr(10'h021, 8'(c << 4) | 8'($random(seed) & 32'h8F) | ((c == 4) ? 8'h08 : 8'h00));
    end
    mwr(10'h005, 8'h00);
    for (int i = 0; i < 4; i++) mwr(10'h019 + 10'(i), 8'($random(seed)));
    // Channel index is always set before the local register is touched.
    foreach (idxs[i]) begin
      mwr(10'h005, idxs[i]);
      mwr(10'h022, 8'($random(seed) & 32'h03));
      mrd(10'h022);
    end
    mwr(10'h100, 8'($random(seed)));
    mrd(10'h100);
    mwr(10'h0FF, 8'($random(seed) & 32'hFE));
    mwr(10'h0FF, 8'h01);
    mwr(10'h101, 8'($random(seed)));
    mwr(10'h102, 8'($random(seed)));
    mwr(10'h3FF, 8'($random(seed)));
    read_all();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    model_reset();
    reset_n <= 1'b1;
    #1;
    chk_outs();
    read_all();
    complete_run();
  end
endmodule // adc_config_register_map_bench
`default_nettype wire
